// *** cad_pkg.sv ***
// Constants and types for the compatibility-area address decoder.
// Assumes a 32-bit AHB-Lite register bus and a 36-bit host address.
package cad_pkg;
	localparam logic [7:0] CAD_OFS_CTRL = 8'h00;
	localparam logic [7:0] CAD_OFS_ATTR = 8'h04;
	localparam logic [7:0] CAD_OFS_STATUS = 8'h08;
	localparam logic [31:0] CAD_CTRL_RESET = 32'h0000_0000;
	// All segments read and write disabled after reset
	localparam logic [25:0] CAD_ATTR_RESET = 26'h000_0000;
	localparam int CAD_CTRL_W = 9;
	localparam int CAD_BIT_AGP_ON = 0;
	localparam int CAD_BIT_MONO = 1;
	localparam int CAD_BIT_GMS_LO = 2;
	localparam int CAD_BIT_GMS_HI = 3;
	localparam int CAD_BIT_BRCMD = 4;
	localparam int CAD_BIT_BRCTL = 5;
	localparam int CAD_BIT_GFXCMD = 6;
	localparam int CAD_BIT_SMM_OPEN = 7;
	localparam int CAD_BIT_SMM_EN = 8;
	localparam int CAD_SEG_COUNT = 13;
	localparam logic [19:0] CAD_DOS_END = 20'hA0000;
	localparam logic [2:0] CAD_VIDEO_TAG = 3'h5;
	localparam logic [4:0] CAD_MONO_TAG = 5'h16;
	localparam logic [19:0] CAD_SEG_BASE = 20'hC0000;
	localparam logic [19:0] CAD_SEG16_END = 20'hF0000;
	localparam logic [15:0] CAD_CNT_RESET = 16'h0000;
	typedef enum logic [2:0] {CAD_TGT_DRAM, CAD_TGT_HUB, CAD_TGT_GFX, CAD_TGT_TERM, CAD_TGT_ABORT} cad_target_t;
	typedef enum logic [1:0] {CAD_SRC_CPU, CAD_SRC_HUB, CAD_SRC_GFX} cad_source_t;
endpackage

// *** cad_segment_lookup.sv ***
// Attribute lookup for the thirteen shadowable compatibility segments.
// Assumes a 20-bit address below 1 MB and a packed read/write enable vector.
`timescale 1ns/10ps
module cad_segment_lookup #(
	parameter int SEGS = cad_pkg::CAD_SEG_COUNT
)(
	input wire logic [19:0] addr,
	input wire logic [2*SEGS-1:0] attr,
	output logic segHit,
	output logic segmentReadEnable,
	output logic segmentWriteEnable
);
	logic [SEGS-1:0] hitVec;
	logic [SEGS-1:0] reVec;
	logic [SEGS-1:0] weVec;
	genvar g;
	generate
		for (g = 0; g < SEGS; g++)
		begin : gSeg
			// Twelve 16 KB segments from C0000h, the last one covers 64 KB
			if (g < SEGS - 1)
			begin : gSmall
				assign hitVec[g] = addr[19:14] == 6'(cad_pkg::CAD_SEG_BASE[19:14] + 6'(g));
			end
			else
			begin : gBios
				assign hitVec[g] = addr >= cad_pkg::CAD_SEG16_END;
			end
			assign reVec[g] = hitVec[g] & attr[2*g];
			assign weVec[g] = hitVec[g] & attr[2*g+1];
		end
	endgenerate
	assign segHit = |hitVec;
	assign segmentReadEnable = |reVec;
	assign segmentWriteEnable = |weVec;
endmodule

// *** cad_decoder.sv ***
// Compatibility-area address decoder with its AHB-Lite configuration registers.
// Assumes requests come from logic on clk; segment ranges are programmed without overlap.
//
// Chosen here: the register offsets and the AHB-Lite register port.
`timescale 1ns/10ps
module cad_decoder #(
	parameter int ADDR_W = 36
)(
	input wire logic clk,
	input wire logic rst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic reqValid,
	input wire logic [ADDR_W-1:0] reqAddr,
	input wire logic reqWrite,
	input wire logic reqIo,
	input wire logic reqSmm,
	input wire logic [1:0] reqSource,
	output logic rspValid,
	output logic [2:0] rspTarget,
	output logic rspZeroData
);
	logic [cad_pkg::CAD_CTRL_W-1:0] ctrl_q;
	logic [cad_pkg::CAD_CTRL_W-1:0] ctrl_d;
	logic [25:0] attr_q;
	logic [25:0] attr_d;
	logic [15:0] aboveCount_q;
	logic [2:0] lastTarget_q;
	logic wrPending_q;
	logic [7:0] wrOfs_q;
	logic [31:0] hrdata_q;
	logic rspValid_q;
	logic [2:0] rspTarget_q;
	logic rspZeroData_q;

	// Bus decode
	wire addrPhase = hsel & hready & htrans[1];
	wire wrCtrl = wrPending_q & (wrOfs_q == cad_pkg::CAD_OFS_CTRL);
	wire wrAttr = wrPending_q & (wrOfs_q == cad_pkg::CAD_OFS_ATTR);
	assign ctrl_d = wrCtrl ? hwdata[cad_pkg::CAD_CTRL_W-1:0] : ctrl_q;
	assign attr_d = wrAttr ? hwdata[25:0] : attr_q;
	// Reads see a write still in its data phase, so back-to-back access needs no wait state
	wire [31:0] rdMux = (haddr[7:0] == cad_pkg::CAD_OFS_CTRL) ? {23'h000000, ctrl_d} :
		(haddr[7:0] == cad_pkg::CAD_OFS_ATTR) ? {6'h00, attr_d} :
		(haddr[7:0] == cad_pkg::CAD_OFS_STATUS) ? {aboveCount_q, 13'h0000, lastTarget_q} : 32'h0000_0000;
	wire mapped = haddr[31:8] == 24'h000000;

	// Configuration fields
	wire agpOn = ctrl_q[cad_pkg::CAD_BIT_AGP_ON];
	wire monoAdapterEnable = ctrl_q[cad_pkg::CAD_BIT_MONO];
	wire [1:0] graphicsMemorySelect = ctrl_q[cad_pkg::CAD_BIT_GMS_HI:cad_pkg::CAD_BIT_GMS_LO];
	wire bridgeCommand = ctrl_q[cad_pkg::CAD_BIT_BRCMD];
	wire bridgeControl = ctrl_q[cad_pkg::CAD_BIT_BRCTL];
	wire graphicsDeviceCommand = ctrl_q[cad_pkg::CAD_BIT_GFXCMD];
	wire smramOpen = ctrl_q[cad_pkg::CAD_BIT_SMM_OPEN];
	wire smramEnable = ctrl_q[cad_pkg::CAD_BIT_SMM_EN];

	// Address classification
	wire above4g = |reqAddr[ADDR_W-1:32];
	wire lowMeg = ~reqIo & (reqAddr[ADDR_W-1:20] == '0);
	wire inDos = lowMeg & (reqAddr[19:0] < cad_pkg::CAD_DOS_END);
	wire inVideo = lowMeg & (reqAddr[19:17] == cad_pkg::CAD_VIDEO_TAG);
	wire inMono = reqAddr[19:15] == cad_pkg::CAD_MONO_TAG;
	wire [9:0] ioPort = reqAddr[9:0];
	wire monoIoPort = reqIo & (reqAddr[ADDR_W-1:10] == '0) & ((ioPort == 10'h3B4) | (ioPort == 10'h3B5) |
		(ioPort == 10'h3B8) | (ioPort == 10'h3B9) | (ioPort == 10'h3BA) | (ioPort == 10'h3BF));
	wire monoActive = agpOn & monoAdapterEnable;
	wire segHit;
	wire segmentReadEnable;
	wire segmentWriteEnable;

	cad_segment_lookup #(
		.SEGS(cad_pkg::CAD_SEG_COUNT)
	) uLookup (
		.addr(reqAddr[19:0]),
		.attr(attr_q),
		.segHit(segHit),
		.segmentReadEnable(segmentReadEnable),
		.segmentWriteEnable(segmentWriteEnable)
	);

	// Video steering; the outcome depends on the source (CPU SMM, graphics port, hub reads)
	wire videoToGfx = agpOn ? (bridgeCommand & bridgeControl) : ((graphicsMemorySelect != 2'h0) & graphicsDeviceCommand);
	wire smmToDram = smramOpen | (reqSmm & smramEnable & (reqSource == 2'(cad_pkg::CAD_SRC_CPU)));
	wire fromGfx = reqSource == 2'(cad_pkg::CAD_SRC_GFX);
	wire fromHub = reqSource == 2'(cad_pkg::CAD_SRC_HUB);
	wire [2:0] videoTarget = smmToDram ? 3'(cad_pkg::CAD_TGT_DRAM) :
		fromGfx ? 3'(cad_pkg::CAD_TGT_ABORT) :
		(monoActive & inMono) ? 3'(cad_pkg::CAD_TGT_HUB) :
		~videoToGfx ? 3'(cad_pkg::CAD_TGT_HUB) :
		(fromHub & ~reqWrite) ? 3'(cad_pkg::CAD_TGT_ABORT) :
		3'(cad_pkg::CAD_TGT_GFX);
	// Disabled segments fall to the hub; their DRAM is simply unreachable
	wire segToDram = reqWrite ? segmentWriteEnable : segmentReadEnable;
	wire [2:0] ioTarget = (monoIoPort & ~monoActive & videoToGfx) ? 3'(cad_pkg::CAD_TGT_GFX) :
		3'(cad_pkg::CAD_TGT_HUB);
	wire [2:0] routeTarget = above4g ? 3'(cad_pkg::CAD_TGT_TERM) :
		reqIo ? ioTarget :
		inDos ? 3'(cad_pkg::CAD_TGT_DRAM) :
		inVideo ? videoTarget :
		(lowMeg & segHit & segToDram) ? 3'(cad_pkg::CAD_TGT_DRAM) :
		3'(cad_pkg::CAD_TGT_HUB);

	// Register bus
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			wrPending_q <= 1'b0;
			wrOfs_q <= 8'h00;
			hrdata_q <= 32'h0000_0000;
			ctrl_q <= cad_pkg::CAD_CTRL_RESET[cad_pkg::CAD_CTRL_W-1:0];
			attr_q <= cad_pkg::CAD_ATTR_RESET;
		end
		else
		begin
			wrPending_q <= addrPhase & hwrite & mapped;
			wrOfs_q <= haddr[7:0];
			hrdata_q <= (addrPhase & ~hwrite & mapped) ? rdMux : 32'h0000_0000;
			ctrl_q <= ctrl_d;
			attr_q <= attr_d;
		end
	end
	assign hrdata = hrdata_q;
	// Zero wait states and always OKAY; kept as flops so outputs stay registered
	logic hreadyout_q;
	logic hresp_q;
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			hreadyout_q <= 1'b0;
			hresp_q <= 1'b0;
		end
		else
		begin
			hreadyout_q <= 1'b1;
			hresp_q <= 1'b0;
		end
	end
	assign hreadyout = hreadyout_q;
	assign hresp = hresp_q;

	// Decode answer, one cycle after the request
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			rspValid_q <= 1'b0;
			rspTarget_q <= 3'(cad_pkg::CAD_TGT_HUB);
			rspZeroData_q <= 1'b0;
			lastTarget_q <= 3'(cad_pkg::CAD_TGT_HUB);
			aboveCount_q <= cad_pkg::CAD_CNT_RESET;
		end
		else
		begin
			rspValid_q <= reqValid;
			rspTarget_q <= reqValid ? routeTarget : rspTarget_q;
			rspZeroData_q <= reqValid & above4g & ~reqWrite;
			lastTarget_q <= reqValid ? routeTarget : lastTarget_q;
			aboveCount_q <= aboveCount_q + 16'((reqValid & above4g) ? 1 : 0);
		end
	end
	assign rspValid = rspValid_q;
	assign rspTarget = rspTarget_q;
	assign rspZeroData = rspZeroData_q;

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	a_above_term: assert property (reqValid & above4g |=> rspValid & (rspTarget == 3'(cad_pkg::CAD_TGT_TERM)))
		else $error("above 4 GB access not terminated");
	a_above_zero: assert property (reqValid & above4g & ~reqWrite |=> rspZeroData)
		else $error("above 4 GB read not zero data");
	a_zero_only: assert property (rspZeroData |-> rspTarget == 3'(cad_pkg::CAD_TGT_TERM))
		else $error("zero data on a non terminated cycle");
	a_dos_dram: assert property (reqValid & inDos |=> rspTarget == 3'(cad_pkg::CAD_TGT_DRAM))
		else $error("DOS area not in DRAM");
	a_gfx_abort: assert property (reqValid & inVideo & fromGfx & ~smmToDram |=>
		rspTarget == 3'(cad_pkg::CAD_TGT_ABORT))
		else $error("graphics video access not aborted");
	a_hub_read_abort: assert property (reqValid & inVideo & fromHub & ~reqWrite & videoToGfx & ~smmToDram
		& ~(monoActive & inMono) |=> rspTarget == 3'(cad_pkg::CAD_TGT_ABORT))
		else $error("hub video read to graphics not aborted");
	a_mono_hub: assert property (reqValid & inVideo & inMono & monoActive & ~smmToDram & ~fromGfx |=>
		rspTarget == 3'(cad_pkg::CAD_TGT_HUB))
		else $error("mono range not sent to hub");
	a_mono_io: assert property (reqValid & monoIoPort & monoActive & ~above4g |=> rspTarget == 3'(cad_pkg::CAD_TGT_HUB))
		else $error("mono I/O port not sent to hub");
	a_seg_read: assert property (reqValid & lowMeg & segHit & ~reqWrite & ~segmentReadEnable |=>
		rspTarget == 3'(cad_pkg::CAD_TGT_HUB))
		else $error("disabled segment read reached DRAM");
	a_shadow_wr: assert property (wrAttr ##1 (reqValid & lowMeg & reqAddr[19:0] >= cad_pkg::CAD_SEG16_END & reqWrite
		& attr_q[25]) |=> rspTarget == 3'(cad_pkg::CAD_TGT_DRAM))
		else $error("shadow write did not reach DRAM");
	a_reset_bios: assert property ($fell(rst) |-> attr_q == cad_pkg::CAD_ATTR_RESET)
		else $error("segment attributes not cleared at reset");

	c_above: cover property (reqValid & above4g ##1 rspZeroData);
	c_video_gfx: cover property (reqValid & inVideo ##1 rspTarget == 3'(cad_pkg::CAD_TGT_GFX));
	c_shadow: cover property (wrAttr ##[1:20] (reqValid & segHit & segToDram));
endmodule

// *** cad_requester.sv ***
// Model of the requesting side: processor bus, hub interface and graphics port.
// Assumes the bench calls send right after a rising edge of clk.
`timescale 1ns/10ps
module cad_requester #(
	parameter int ADDR_W = 36
)(
	input wire logic clk,
	output logic reqValid,
	output logic [ADDR_W-1:0] reqAddr,
	output logic reqWrite,
	output logic reqIo,
	output logic reqSmm,
	output logic [1:0] reqSource
);
	initial
	begin
		reqValid = 1'b0;
		reqAddr = '0;
		reqWrite = 1'b0;
		reqIo = 1'b0;
		reqSmm = 1'b0;
		reqSource = 2'h0;
	end
	task automatic send(input logic [ADDR_W-1:0] a, input logic w, input logic io, input logic smm,
		input logic [1:0] src);
		reqValid <= 1'b1;
		reqAddr <= a;
		reqWrite <= w;
		reqIo <= io;
		reqSmm <= smm;
		reqSource <= src;
		@(posedge clk);
		// Released valid, address, write and SMM lines change, so a stale value never passes for a live one
		reqValid <= 1'b0;
		reqAddr <= ~a;
		reqWrite <= ~w;
		reqSmm <= ~smm;
		@(posedge clk);
	endtask
endmodule

// *** cad_decoder_tb_top.sv ***
// Self-checking bench for the compatibility-area decoder.
// Assumes one clock; decode answers are matched in order against a queue.
`timescale 1ns/10ps
module cad_decoder_tb_top;
	logic clk, rst, hsel, hwrite, hready, hreadyout, hresp, rspValid, rspZeroData;
	logic reqValid, reqWrite, reqIo, reqSmm;
	logic [1:0] htrans, reqSource;
	logic [31:0] haddr, hwdata, hrdata, attr;
	logic [35:0] reqAddr;
	logic [2:0] rspTarget;
	logic [3:0] expQ[$];
	logic [15:0] lfsr;
	logic [11:0] monoPorts[6] = '{12'h3B4, 12'h3B5, 12'h3B8, 12'h3B9, 12'h3BA, 12'h3BF};
	int n_mismatch = 0;
	int compares = 0;
	assign hready = hreadyout;
	cad_decoder DUT (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(3'h2), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.reqValid(reqValid), .reqAddr(reqAddr), .reqWrite(reqWrite), .reqIo(reqIo), .reqSmm(reqSmm),
		.reqSource(reqSource), .rspValid(rspValid), .rspTarget(rspTarget), .rspZeroData(rspZeroData));
	cad_requester REQ (.clk(clk), .reqValid(reqValid), .reqAddr(reqAddr), .reqWrite(reqWrite), .reqIo(reqIo),
		.reqSmm(reqSmm), .reqSource(reqSource));
	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	function automatic logic [15:0] lfsrNext(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask
	task automatic results();
		if (n_mismatch == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// Single word transfer; a read compares the data phase value
	task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d, input logic [31:0] exp);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		do @(posedge clk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hready !== 1'b1);
		if (!w)
			check(hrdata, exp);
	endtask
	task automatic req(input logic [35:0] a, input logic w, input logic io, input logic smm, input logic [1:0] src,
		input logic [2:0] tgt);
		expQ.push_back({a[35:32] != 4'h0 && !w, tgt});
		REQ.send(a, w, io, smm, src);
	endtask
	// Answers pop the oldest note; an unexpected answer counts as a mismatch
	always @(posedge clk)
		if (rspValid === 1'b1)
		begin
			if (expQ.size() == 0)
				check(32'h1, 32'h0);
			else
			begin
				check({28'h0, rspZeroData, rspTarget}, {28'h0, expQ[0]});
				void'(expQ.pop_front());
			end
		end
	initial
	begin
		#(40 * 5000);
		n_mismatch++;
		results();
	end
	initial
	begin
		rst = 1'b1;
		{hsel, hwrite, htrans, haddr, hwdata} = '0;
		lfsr = 16'h0060;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		repeat (2) @(posedge clk);
		bus(32'h0, 1'b0, 32'h0, 32'h0);
		bus(32'h4, 1'b0, 32'h0, 32'h0);
		bus(32'h100, 1'b1, 32'hFFFF_FFFF, 32'h0);
		bus(32'h100, 1'b0, 32'h0, 32'h0);
		req(36'h0_000F_8000, 1'b0, 1'b0, 1'b0, 2'h0, cad_pkg::CAD_TGT_HUB);
		req(36'h1_0000_0000, 1'b0, 1'b0, 1'b0, 2'h0, cad_pkg::CAD_TGT_TERM);
		req(36'hF_FFFF_FFFC, 1'b1, 1'b0, 1'b0, 2'h0, cad_pkg::CAD_TGT_TERM);
		// Shadowing: write-only copies in, read-only serves from DRAM
		bus(32'h4, 1'b1, 32'h0200_0000, 32'h0);
		req(36'h0_000F_0000, 1'b1, 1'b0, 1'b0, 2'h0, cad_pkg::CAD_TGT_DRAM);
		req(36'h0_000F_0000, 1'b0, 1'b0, 1'b0, 2'h0, cad_pkg::CAD_TGT_HUB);
		bus(32'h4, 1'b1, 32'h0100_0000, 32'h0);
		req(36'h0_000F_FFFC, 1'b0, 1'b0, 1'b0, 2'h0, cad_pkg::CAD_TGT_DRAM);
		// Registers hold one setting each, so programmed ranges cannot overlap
		for (int k = 0; k < 4; k++)
		begin
			lfsr = lfsrNext(lfsrNext(lfsr));
			attr = {6'h0, lfsr[9:0], lfsrNext(lfsr)};
			bus(32'h4, 1'b1, attr, 32'h0);
			bus(32'h4, 1'b0, 32'h0, attr);
			req({20'h0, lfsr[15:0] % 16'hA000}, lfsr[0], 1'b0, 1'b0, 2'h0, cad_pkg::CAD_TGT_DRAM);
			for (int i = 0; i < 13; i++)
				for (int w = 0; w < 2; w++)
					req(36'(i < 8 ? 32'hC0000 + i * 32'h4000 : 32'hE0000 + (i - 8) * 32'h4000) + 36'(lfsr[13:0]),
						w[0], 1'b0, 1'b0, 2'h0, attr[2 * i + w] ? cad_pkg::CAD_TGT_DRAM : cad_pkg::CAD_TGT_HUB);
		end
		bus(32'h4, 1'b1, 32'h03FF_FFFF, 32'h0);
		req(36'h0_000A_0000, 1'b0, 1'b0, 1'b0, 2'h0, cad_pkg::CAD_TGT_HUB);
		bus(32'h0, 1'b1, 32'h0000_0044, 32'h0);
		bus(32'h0, 1'b0, 32'h0, 32'h0000_0044);
		req(36'h0_000A_0000, 1'b0, 1'b0, 1'b0, 2'h0, cad_pkg::CAD_TGT_GFX);
		req(36'h0_000B_0000, 1'b1, 1'b0, 1'b0, 2'h1, cad_pkg::CAD_TGT_GFX);
		req(36'h0_000B_0000, 1'b0, 1'b0, 1'b0, 2'h1, cad_pkg::CAD_TGT_ABORT);
		req(36'h0_000A_8000, 1'b1, 1'b0, 1'b0, 2'h2, cad_pkg::CAD_TGT_ABORT);
		req(36'h0_0009_FFFC, 1'b1, 1'b0, 1'b0, 2'h1, cad_pkg::CAD_TGT_DRAM);
		bus(32'h0, 1'b1, 32'h0000_0031, 32'h0);
		req(36'h0_000B_FFFC, 1'b0, 1'b0, 1'b0, 2'h0, cad_pkg::CAD_TGT_GFX);
		req(36'h0_000B_0000, 1'b1, 1'b0, 1'b0, 2'h0, cad_pkg::CAD_TGT_GFX);
		bus(32'h0, 1'b1, 32'h0000_0033, 32'h0);
		req(36'h0_000B_0000, 1'b0, 1'b0, 1'b0, 2'h0, cad_pkg::CAD_TGT_HUB);
		req(36'h0_000B_7FFC, 1'b1, 1'b0, 1'b0, 2'h0, cad_pkg::CAD_TGT_HUB);
		req(36'h0_000B_8000, 1'b0, 1'b0, 1'b0, 2'h0, cad_pkg::CAD_TGT_GFX);
		for (int j = 0; j < 6; j++)
			req(36'(monoPorts[j]), j[0], 1'b1, 1'b0, 2'h0, cad_pkg::CAD_TGT_HUB);
		bus(32'h0, 1'b1, 32'h0000_0131, 32'h0);
		req(36'h0_000A_0000, 1'b0, 1'b0, 1'b1, 2'h0, cad_pkg::CAD_TGT_DRAM);
		req(36'h0_000A_0000, 1'b0, 1'b0, 1'b0, 2'h0, cad_pkg::CAD_TGT_GFX);
		repeat (3) @(posedge clk);
		check(32'(expQ.size()), 32'h0);
		results();
	end
endmodule
